/* File: logic/plc_cell.sv */
// Datapath of one logic cell: input muxes, gates, function stage and output inversion
module plc_cell (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Candidate inputs
	input wire logic [15:0] cell_in_i,
	// Configuration
	input wire logic [11:0] mux_code_i,
	input wire logic [31:0] gate_sel_i,
	input wire logic [3:0] gate_invert_bits_i,
	input wire logic result_invert_i,
	input wire logic cell_enable_i,
	input wire logic [2:0] function_select_i,
	// Final cell output, combinational
	output logic final_o
);

	// ************************************************************
	// Data selection
	// ************************************************************

	// Mux k sees inputs 4k..4k+7, wrapping past 15 for mux 4
	function automatic logic mux_pick(input logic [15:0] v, input logic [1:0] k,
		input logic [2:0] code);
		logic [3:0] idx;
		idx = {k, 2'b00} + {1'b0, code};
		return v[idx];
	endfunction

	logic [3:0] data_sel;
	logic [3:0] gate_val;
	logic [3:0] both_forms;
	logic [7:0] terms;

	// Odd bits take each input true, even bits take it inverted
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mux
			assign data_sel[gi] = mux_pick(cell_in_i, 2'(gi), mux_code_i[3*gi +: 3]);
			assign terms[2*gi] = ~data_sel[gi];
			assign terms[2*gi+1] = data_sel[gi];
		end
	endgenerate

	// ************************************************************
	// Data gating
	// ************************************************************

	// Raw gate is the OR of enabled terms, i.e. the inverted AND of their complements;
	// no terms gives 0, so the invert bit alone sets a constant level
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gate
			// Both forms of one input enabled: gate held at zero whatever its polarity bit
			assign both_forms[gi] = |(gate_sel_i[8*gi +: 8] &
				(gate_sel_i[8*gi +: 8] >> 1) & 8'h55);
			assign gate_val[gi] = ~both_forms[gi] & (gate_invert_bits_i[gi] ^
				(|(gate_sel_i[8*gi +: 8] & terms)));
		end
	endgenerate

	// ************************************************************
	// Function stage
	// ************************************************************
	logic state_ff;
	logic nxt_state;
	logic g1_prev_ff;
	logic g1_rise;
	logic comb_val;
	logic func_val;
	logic is_seq;

	// Gate 1 acts as clock; its edge is seen against the previous sample
	assign g1_rise = gate_val[0] & ~g1_prev_ff;
	assign is_seq = function_select_i inside {plc_pkg::PLC_SR_LATCH, plc_pkg::PLC_DFF_SR,
		plc_pkg::PLC_DFF2_R, plc_pkg::PLC_JK_R, plc_pkg::PLC_TLATCH_SR};

	// Combinational functions
	always_comb begin
		unique case (plc_pkg::plc_mode_e'(function_select_i))
			plc_pkg::PLC_AND_OR: comb_val = (gate_val[0] & gate_val[1]) |
				(gate_val[2] & gate_val[3]);
			plc_pkg::PLC_OR_XOR: comb_val = (gate_val[0] | gate_val[1]) ^
				(gate_val[2] | gate_val[3]);
			plc_pkg::PLC_AND4: comb_val = &gate_val;
			default: comb_val = 1'b0;
		endcase
	end

	// Storage functions; reset and set override the clock edge each cycle
	always_comb begin
		nxt_state = state_ff;
		unique case (plc_pkg::plc_mode_e'(function_select_i))
			plc_pkg::PLC_SR_LATCH: begin
				if (gate_val[0] | gate_val[1]) begin
					nxt_state = 1'b1;
				end else if (gate_val[2] | gate_val[3]) begin
					nxt_state = 1'b0;
				end
			end
			plc_pkg::PLC_DFF_SR: begin
				if (gate_val[2]) begin
					nxt_state = 1'b0;
				end else if (gate_val[3]) begin
					nxt_state = 1'b1;
				end else if (g1_rise) begin
					nxt_state = gate_val[1];
				end
			end
			plc_pkg::PLC_DFF2_R: begin
				if (gate_val[2]) begin
					nxt_state = 1'b0;
				end else if (g1_rise) begin
					nxt_state = gate_val[1] & gate_val[3];
				end
			end
			plc_pkg::PLC_JK_R: begin
				if (gate_val[2]) begin
					nxt_state = 1'b0;
				end else if (g1_rise) begin
					unique case ({gate_val[1], gate_val[3]})
						2'b10: nxt_state = 1'b1;
						2'b01: nxt_state = 1'b0;
						2'b11: nxt_state = ~state_ff;
						default: nxt_state = state_ff;
					endcase
				end
			end
			plc_pkg::PLC_TLATCH_SR: begin
				if (gate_val[2]) begin
					nxt_state = 1'b0;
				end else if (gate_val[3]) begin
					nxt_state = 1'b1;
				end else if (gate_val[0]) begin
					nxt_state = gate_val[1];
				end
			end
			default: nxt_state = state_ff;
		endcase
	end

	// Stored value only moves while the cell is enabled
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= 1'b0;
			g1_prev_ff <= 1'b0;
		end else begin
			g1_prev_ff <= gate_val[0];
			if (cell_enable_i) begin
				state_ff <= nxt_state;
			end
		end
	end

	// ************************************************************
	// Output inversion and enable
	// ************************************************************
	assign func_val = is_seq ? state_ff : comb_val;
	assign final_o = cell_enable_i & (result_invert_i ^ func_val);

endmodule // plc_cell

/* File: logic/plc_pkg.sv */
// Package: register map, field layout, reset values and function codes of the logic cell
package plc_pkg;

	// ************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] CELL_STRIDE = 12'h020;
	localparam logic [4:0] OFF_CON = 5'h00;
	localparam logic [4:0] OFF_POL = 5'h04;
	localparam logic [4:0] OFF_SEL_A = 5'h08;
	localparam logic [4:0] OFF_SEL_B = 5'h0C;
	localparam logic [4:0] OFF_GLS0 = 5'h10;
	localparam logic [4:0] OFF_GLS1 = 5'h14;
	localparam logic [4:0] OFF_GLS2 = 5'h18;
	localparam logic [4:0] OFF_GLS3 = 5'h1C;
	localparam logic [11:0] OFF_MIRROR = 12'h100;
	localparam logic [11:0] OFF_FLAG = 12'h104;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int unsigned CON_EN = 7;
	localparam int unsigned CON_OE = 6;
	localparam int unsigned CON_OUT = 5;
	localparam int unsigned CON_INTP = 4;
	localparam int unsigned CON_INTN = 3;
	localparam int unsigned CON_MODE_LSB = 0;
	localparam logic [7:0] CON_RESET = 8'h00;
	localparam logic [7:0] CON_WMASK = 8'hDF;

	// ************************************************************
	// Polarity and mux select fields
	// ************************************************************
	localparam int unsigned POL_RESULT = 7;
	localparam logic RESULT_INV_RESET = 1'b0;
	localparam int unsigned SEL_LO_LSB = 0;
	localparam int unsigned SEL_HI_LSB = 4;

	// ************************************************************
	// Input wiring and pin synchroniser
	// ************************************************************
	localparam int unsigned IN_FOSC = 4;
	localparam int unsigned IN_T0 = 5;
	localparam int unsigned IN_T1 = 6;
	localparam int unsigned IN_T2 = 7;
	localparam int unsigned IN_CELL1 = 8;
	localparam int unsigned IN_CELL2 = 9;
	localparam int unsigned SYNC_STAGES = 3;

	// ************************************************************
	// Logic function codes
	// ************************************************************
	typedef enum logic [2:0] {
		PLC_AND_OR = 3'h0,
		PLC_OR_XOR = 3'h1,
		PLC_AND4 = 3'h2,
		PLC_SR_LATCH = 3'h3,
		PLC_DFF_SR = 3'h4,
		PLC_DFF2_R = 3'h5,
		PLC_JK_R = 3'h6,
		PLC_TLATCH_SR = 3'h7
	} plc_mode_e;

endpackage // plc_pkg

/* File: logic/plc_top.sv */
// Top of the programmable logic cells: APB register file, input wiring, edge flags, mirror
//
// Behaviour
// - Four muxes each pick one of eight inputs with a 3-bit code.
// - Mux 1 sees inputs 0-7, mux 2 inputs 4-11, mux 3 inputs 8-15.
// - Mux 4 codes 0-3 pick inputs 12-15, codes 4-7 pick inputs 0-3.
// - Inputs 4-9 are clock, timers and cell outputs; 12-15 per instance.
// - Mux select fields have no defined value after power-up.
// - Each gate combines any subset of selected signals, true or inverted.
// - Each gate result can be inverted by its own polarity bit.
// - Select 0x55 and 0xAA give AND, NAND, NOR, OR by polarity.
// - A gate with nothing selected outputs its polarity bit.
// - Selecting both forms of one input forces the gate to a constant.
// - Four identical gates, each with its own select register.
// - Gate selects have no defined value after power-up.
// - The four gate results feed the selected function.
// - Function result goes through inversion to peripherals, pin and feedback.
// - Output invert bit inverts the function result.
// - An edge caused by toggling output invert counts like any edge.
// - Separate rising and falling detectors, each gated by its enable.
// - Qualifying edge sets a sticky flag until software clears it.
// - An edge wins over a simultaneous software clear.
// - One mirror register shows all cell outputs captured together.
// - Reset clears the control register and the output invert bit; selects and gate polarities keep.
// - Function codes: AND-OR, OR-XOR, AND, SR, DFF-SR, DFF2-R, JK-R, latch.
// - Disabled cell outputs zero and does not process inputs.
// - Control register shows the final output as a read-only bit.
//
// The APB register port and the register offsets were chosen for this implementation.
module plc_top #(
	parameter int unsigned NCELL = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [plc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Sources on this clock
	input wire logic timer0_wrap_i,
	input wire logic timer1_wrap_i,
	input wire logic timer2_period_hit_i,
	// Sources from pins or other clocks, two pins and four specific per cell
	input wire logic [2*NCELL-1:0] pin_in_i,
	input wire logic [4*NCELL-1:0] inst_src_i,
	// Cell results
	output logic [NCELL-1:0] cell_out_o,
	output logic [NCELL-1:0] pin_o,
	output logic [NCELL-1:0] pin_oe_o,
	output logic [NCELL-1:0] cell_irq_flag_o
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// Feedback needs cells 1 and 2; the decode holds eight cells below the mirror
	if (NCELL < 2 || NCELL > 8) begin : g_bad_ncell
		$error("plc_top: NCELL must be between 2 and 8");
	end

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	localparam int unsigned NASYNC = 6 * NCELL;
	logic [NASYNC-1:0] async_in;
	logic [NASYNC-1:0] sync1_ff;
	logic [NASYNC-1:0] sync2_ff;
	logic [NASYNC-1:0] sync3_ff;
	logic [NASYNC-1:0] filt_ff;
	logic [NASYNC-1:0] nxt_filt;

	assign async_in = {inst_src_i, pin_in_i};

	// Three stages; a change is taken once stages two and three agree
	assign nxt_filt = (sync2_ff ~^ sync3_ff) & sync3_ff | ~(sync2_ff ~^ sync3_ff) & filt_ff;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
			filt_ff <= '0;
		end else begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			filt_ff <= nxt_filt;
		end
	end

	// ************************************************************
	// System clock as a data source
	// ************************************************************
	// The clock itself cannot be sampled on its own edge; a half-rate square stands in
	logic fosc_ff;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fosc_ff <= 1'b0;
		end else begin
			fosc_ff <= ~fosc_ff;
		end
	end

	// ************************************************************
	// APB decode
	// ************************************************************
	logic [2:0] cell_idx;
	logic [4:0] reg_off;
	logic cell_space;
	logic cell_hit;
	logic mirror_hit;
	logic flag_hit;
	logic addr_hit;
	logic bus_write;
	logic bus_setup;

	assign cell_idx = paddr_i[7:5];
	assign reg_off = {paddr_i[4:2], 2'b00};
	assign cell_space = (paddr_i[plc_pkg::ADDR_W-1:8] == '0);
	assign cell_hit = cell_space && (32'(cell_idx) < NCELL);
	assign mirror_hit = ({paddr_i[11:2], 2'b00} == plc_pkg::OFF_MIRROR);
	assign flag_hit = ({paddr_i[11:2], 2'b00} == plc_pkg::OFF_FLAG);
	assign addr_hit = cell_hit | mirror_hit | flag_hit;
	assign bus_write = psel_i & penable_i & pwrite_i & addr_hit;
	assign bus_setup = psel_i & ~penable_i;

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~addr_hit;

	// ************************************************************
	// Per-cell registers and datapath
	// ************************************************************
	logic [NCELL-1:0] final_out;
	logic [NCELL-1:0] out_ff;
	logic [NCELL-1:0] flag_ff;
	logic [7:0] con_rd [NCELL];
	logic [7:0] pol_rd [NCELL];
	logic [7:0] sel_a_rd [NCELL];
	logic [7:0] sel_b_rd [NCELL];
	logic [31:0] gls_rd [NCELL];

	genvar ci;
	generate
		for (ci = 0; ci < NCELL; ci++) begin : g_cell
			logic [7:0] con_ff;
			logic result_invert_ff;
			logic [3:0] gate_inv_ff;
			logic [11:0] mux_code_ff;
			logic [31:0] gls_ff;
			logic wr_here;
			logic [15:0] cell_in;
			logic rise_hit;
			logic fall_hit;
			logic flag_clear;

			assign wr_here = bus_write & cell_hit & (32'(cell_idx) == ci);

			// Control register and output invert bit are cleared by reset
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					con_ff <= plc_pkg::CON_RESET;
					result_invert_ff <= plc_pkg::RESULT_INV_RESET;
				end else if (wr_here && reg_off == plc_pkg::OFF_CON) begin
					con_ff <= pwdata_i[7:0] & plc_pkg::CON_WMASK;
				end else if (wr_here && reg_off == plc_pkg::OFF_POL) begin
					result_invert_ff <= pwdata_i[plc_pkg::POL_RESULT];
				end
			end

			// Selects and gate settings carry no reset, so they survive one
			always_ff @(posedge clk_i) begin
				if (wr_here && reg_off == plc_pkg::OFF_POL) begin
					gate_inv_ff <= pwdata_i[3:0];
				end
				if (wr_here && reg_off == plc_pkg::OFF_SEL_A) begin
					mux_code_ff[5:0] <= {pwdata_i[plc_pkg::SEL_HI_LSB +: 3],
						pwdata_i[plc_pkg::SEL_LO_LSB +: 3]};
				end
				if (wr_here && reg_off == plc_pkg::OFF_SEL_B) begin
					mux_code_ff[11:6] <= {pwdata_i[plc_pkg::SEL_HI_LSB +: 3],
						pwdata_i[plc_pkg::SEL_LO_LSB +: 3]};
				end
				if (wr_here && reg_off == plc_pkg::OFF_GLS0) begin
					gls_ff[7:0] <= pwdata_i[7:0];
				end
				if (wr_here && reg_off == plc_pkg::OFF_GLS1) begin
					gls_ff[15:8] <= pwdata_i[7:0];
				end
				if (wr_here && reg_off == plc_pkg::OFF_GLS2) begin
					gls_ff[23:16] <= pwdata_i[7:0];
				end
				if (wr_here && reg_off == plc_pkg::OFF_GLS3) begin
					gls_ff[31:24] <= pwdata_i[7:0];
				end
			end

			// Input wiring; feedback uses the registered outputs to avoid loops
			assign cell_in[1:0] = filt_ff[2*ci +: 2];
			assign cell_in[3:2] = 2'b00;
			assign cell_in[plc_pkg::IN_FOSC] = fosc_ff;
			assign cell_in[plc_pkg::IN_T0] = timer0_wrap_i;
			assign cell_in[plc_pkg::IN_T1] = timer1_wrap_i;
			assign cell_in[plc_pkg::IN_T2] = timer2_period_hit_i;
			assign cell_in[plc_pkg::IN_CELL1] = out_ff[0];
			assign cell_in[plc_pkg::IN_CELL2] = out_ff[1];
			assign cell_in[11:10] = 2'b00;
			assign cell_in[15:12] = filt_ff[2*NCELL + 4*ci +: 4];

			plc_cell u_cell (
				.clk_i(clk_i),
				.arst_n_i(arst_n_i),
				.cell_in_i(cell_in),
				.mux_code_i(mux_code_ff),
				.gate_sel_i(gls_ff),
				.gate_invert_bits_i(gate_inv_ff),
				.result_invert_i(result_invert_ff),
				.cell_enable_i(con_ff[plc_pkg::CON_EN]),
				.function_select_i(con_ff[plc_pkg::CON_MODE_LSB +: 3]),
				.final_o(final_out[ci])
			);

			// Edge detectors compare the live output with last cycle's sample
			assign rise_hit = final_out[ci] & ~out_ff[ci] & con_ff[plc_pkg::CON_INTP];
			assign fall_hit = ~final_out[ci] & out_ff[ci] & con_ff[plc_pkg::CON_INTN];
			assign flag_clear = bus_write & flag_hit & pwdata_i[ci];

			// Sticky flag; a new edge beats a clear in the same cycle
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					out_ff[ci] <= 1'b0;
					flag_ff[ci] <= 1'b0;
				end else begin
					out_ff[ci] <= final_out[ci];
					if (rise_hit || fall_hit) begin
						flag_ff[ci] <= 1'b1;
					end else if (flag_clear) begin
						flag_ff[ci] <= 1'b0;
					end
				end
			end

			// Readback views
			assign con_rd[ci] = {con_ff[7:6], out_ff[ci], con_ff[4:0]};
			assign pol_rd[ci] = {result_invert_ff, 3'b000, gate_inv_ff};
			assign sel_a_rd[ci] = {1'b0, mux_code_ff[5:3], 1'b0, mux_code_ff[2:0]};
			assign sel_b_rd[ci] = {1'b0, mux_code_ff[11:9], 1'b0, mux_code_ff[8:6]};
			assign gls_rd[ci] = gls_ff;

			assign pin_oe_o[ci] = con_ff[plc_pkg::CON_OE];
		end
	endgenerate

	// ************************************************************
	// Read path
	// ************************************************************
	logic [31:0] rd_data;
	logic [31:0] prdata_ff;

	// All cell outputs come from one register sample, so the mirror has no skew
	always_comb begin
		rd_data = 32'h0000_0000;
		if (mirror_hit) begin
			rd_data = 32'(out_ff);
		end else if (flag_hit) begin
			rd_data = 32'(flag_ff);
		end else if (cell_hit) begin
			for (int i = 0; i < NCELL; i++) begin
				if (32'(cell_idx) == i) begin
					unique case (reg_off)
						plc_pkg::OFF_CON: rd_data = {24'h000000, con_rd[i]};
						plc_pkg::OFF_POL: rd_data = {24'h000000, pol_rd[i]};
						plc_pkg::OFF_SEL_A: rd_data = {24'h000000, sel_a_rd[i]};
						plc_pkg::OFF_SEL_B: rd_data = {24'h000000, sel_b_rd[i]};
						plc_pkg::OFF_GLS0: rd_data = {24'h000000, gls_rd[i][7:0]};
						plc_pkg::OFF_GLS1: rd_data = {24'h000000, gls_rd[i][15:8]};
						plc_pkg::OFF_GLS2: rd_data = {24'h000000, gls_rd[i][23:16]};
						plc_pkg::OFF_GLS3: rd_data = {24'h000000, gls_rd[i][31:24]};
						default: rd_data = 32'h0000_0000;
					endcase
				end
			end
		end
	end

	// Read data captured in the setup cycle and held through the access cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (bus_setup) begin
			prdata_ff <= rd_data;
		end
	end

	assign prdata_o = prdata_ff;

	// ************************************************************
	// Outputs
	// ************************************************************
	// Peripherals and pin see the registered output, one cycle behind the cell
	assign cell_out_o = out_ff;
	assign pin_o = out_ff;
	assign cell_irq_flag_o = flag_ff;

endmodule // plc_top

/* File: sim/plc_chk.sv */
// Checker: concurrent assertions on the ports of the logic cell top
module plc_chk #(
	parameter int unsigned NCELL = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [plc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Cell results
	input wire logic [NCELL-1:0] cell_out_o,
	input wire logic [NCELL-1:0] pin_o,
	input wire logic [NCELL-1:0] cell_irq_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Access decode, cell 0 flag clear
	wire rd_acc = psel_i & penable_i & !pwrite_i;
	wire flag_clr = psel_i & penable_i & pwrite_i & (paddr_i == plc_pkg::OFF_FLAG) & pwdata_i[0];

	// ************************************************************
	// Properties
	// ************************************************************
	a_ready_high: assert property (pready_o)
		else $error("pready low");
	a_pin_copy: assert property (pin_o == cell_out_o)
		else $error("pin differs from cell output");
	a_mirror_read: assert property (rd_acc && paddr_i == plc_pkg::OFF_MIRROR
		|-> prdata_o[NCELL-1:0] == $past(cell_out_o)) else $error("mirror mismatch");
	a_con_result: assert property (rd_acc && paddr_i == 12'h000
		|-> prdata_o[plc_pkg::CON_OUT] == $past(cell_out_o[0])) else $error("result bit wrong");
	a_flag_hold: assert property (cell_irq_flag_o[0] && !flag_clr |=> cell_irq_flag_o[0])
		else $error("flag dropped");
	a_clear_wins: assert property (flag_clr |=> !cell_irq_flag_o[0] || $changed(cell_out_o[0]))
		else $error("flag not cleared");
	a_flag_cause: assert property ($rose(cell_irq_flag_o[0]) |-> $changed(cell_out_o[0]))
		else $error("flag without edge");
	a_bad_addr: assert property (psel_i && penable_i && paddr_i == 12'hFF0 |-> pslverr_o)
		else $error("no error on unmapped");
	a_good_addr: assert property (psel_i && penable_i && paddr_i < 12'(NCELL * 32) |-> !pslverr_o)
		else $error("error on mapped");
endmodule // plc_chk

bind plc_top plc_chk #(.NCELL(NCELL)) i_plc_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.cell_out_o(cell_out_o), .pin_o(pin_o), .cell_irq_flag_o(cell_irq_flag_o));

/* File: sim/plc_src_model.sv */
// Partner model: timer, pin and instance sources feeding the cells
module plc_src_model (
	// Clock
	input wire logic clk_i,
	// Requested levels: t0, t1, t2, pin0, pin1, inst0..3
	input wire logic [8:0] drive_i,
	// Source levels
	output logic timer0_wrap_o,
	output logic timer1_wrap_o,
	output logic timer2_period_hit_o,
	output logic [3:0] pin_o,
	output logic [7:0] inst_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sources move just after the clock, as on-chip peripherals do
	always @(posedge clk_i) begin
		{timer2_period_hit_o, timer1_wrap_o, timer0_wrap_o} <= drive_i[2:0];
		pin_o <= {2{drive_i[4:3]}}; // Both cells see the same pins
		inst_o <= {2{drive_i[8:5]}};
	end
endmodule // plc_src_model

/* File: sim/tb_plc_top.sv */
// Testbench: APB register tests of the logic cell top
module tb_plc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, arst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
	logic pready_o, pslverr_o, rerr, t0, t1, t2;
	logic [3:0] pins;
	logic [7:0] inst;
	logic [1:0] cell_out_o, pin_o, pin_oe_o, cell_irq_flag_o;
	logic [8:0] drive = 9'h000;
	int err_total = 0, samples_checked = 0, i, m;
	// Path table: SEL_A, SEL_B, gate 1 select, sources, expected output
	logic [7:0] ra [9] = '{8'h05, 8'h07, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05};
	logic [7:0] rb [9] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h30, 8'h50, 8'h00, 8'h00, 8'h00};
	logic [7:0] rg [9] = '{8'h02, 8'h02, 8'h08, 8'h20, 8'h80, 8'h80, 8'h02, 8'h01, 8'h02};
	logic [8:0] rs [9] = '{9'h001, 9'h004, 9'h002, 9'h020, 9'h100, 9'h010, 9'h008, 9'h000, 9'h1FE};
	logic re [9] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
	// Latch steps: gate levels and expected output
	logic [3:0] sg [4] = '{4'h1, 4'h0, 4'h4, 4'h5};
	logic se [4] = '{1'h1, 1'h1, 1'h0, 1'h1};

	plc_top #(.NCELL(2)) i_plc_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .timer0_wrap_i(t0),
		.timer1_wrap_i(t1), .timer2_period_hit_i(t2), .pin_in_i(pins), .inst_src_i(inst),
		.cell_out_o(cell_out_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.cell_irq_flag_o(cell_irq_flag_o));
	plc_src_model i_plc_src_model (.clk_i(clk_i), .drive_i(drive), .timer0_wrap_o(t0),
		.timer1_wrap_o(t1), .timer2_period_hit_o(t2), .pin_o(pins), .inst_o(inst));

	// ************************************************************
	// Tasks
	// ************************************************************
	// 200 MHz clock
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, 1'h0, w, a, d};
		@(posedge clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 50);
		if (n >= 50) begin
			err_total++;
			test_done();
		end
		rdat = prdata_o;
		rerr = pslverr_o;
		{psel_i, penable_i} <= 2'h0;
	endtask
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_reg({31'h0, got}, {31'h0, exp});
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'h0, 32'h0);
		cmp_reg(rdat, exp);
	endtask
	function automatic logic fexp(input logic [2:0] f, input logic [3:0] g);
		case (f)
			3'h0: fexp = (g[0] & g[1]) | (g[2] & g[3]);
			3'h1: fexp = (g[0] | g[1]) ^ (g[2] | g[3]);
			default: fexp = &g;
		endcase
	endfunction

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'h1;
		rd_chk(12'h000, 32'h0);
		rd_chk(12'h104, 32'h0);
		apb(12'hFF0, 1'h0, 32'h0);
		cmp_bit(rerr, 1'h1);
		$display("reset test done");
		// All four gate selects cleared first so no unset mux code reaches the output; gates 2-4 held at one
		for (i = 0; i < 4; i++) apb(12'h010 + 12'(4 * i), 1'h1, 32'h0);
		apb(12'h004, 1'h1, 32'h0E);
		apb(12'h000, 1'h1, 32'h82);
		// Sync path is five edges, so eight cycles is safe
		for (i = 0; i < 9; i++) begin
			apb(12'h008, 1'h1, {24'h0, ra[i]});
			apb(12'h00C, 1'h1, {24'h0, rb[i]});
			apb(12'h010, 1'h1, {24'h0, rg[i]});
			drive <= rs[i];
			repeat (8) @(posedge clk_i);
			cmp_bit(cell_out_o[0], re[i]);
		end
		drive <= 9'h000;
		$display("path test done");
		apb(12'h010, 1'h1, 32'h0);
		for (m = 0; m < 3; m++) begin
			apb(12'h000, 1'h1, 32'h80 | 32'(m));
			for (i = 0; i < 32; i++) begin
				apb(12'h004, 1'h1, {24'h0, i[4], 3'h0, i[3:0]});
				rd_chk(12'h000, {24'h0, 2'h2, fexp(m[2:0], i[3:0]) ^ i[4], 2'h0, m[2:0]});
			end
		end
		apb(12'h000, 1'h1, 32'h83);
		for (i = 0; i < 4; i++) begin
			apb(12'h004, 1'h1, {28'h0, sg[i]});
			// State register adds one cycle before the output shows it
			@(posedge clk_i);
			rd_chk(12'h000, {24'h0, 2'h2, se[i], 5'h03});
		end
		// Both forms of input 1 in gate 1 force it low even with polarity 0
		apb(12'h000, 1'h1, 32'h82);
		apb(12'h010, 1'h1, 32'h03);
		apb(12'h004, 1'h1, 32'h0E);
		rd_chk(12'h000, 32'h82);
		apb(12'h010, 1'h1, 32'h0);
		$display("function test done");
		apb(12'h004, 1'h1, 32'h0F);
		apb(12'h000, 1'h1, 32'h42);
		rd_chk(12'h000, 32'h42);
		cmp_bit(cell_out_o[0], 1'h0);
		cmp_bit(pin_oe_o[0], 1'h1);
		apb(12'h104, 1'h1, 32'h3);
		apb(12'h000, 1'h1, 32'h92);
		rd_chk(12'h104, 32'h1);
		apb(12'h104, 1'h1, 32'h1);
		apb(12'h004, 1'h1, 32'h8F);
		rd_chk(12'h104, 32'h0);
		apb(12'h004, 1'h1, 32'h0F);
		rd_chk(12'h104, 32'h1);
		rd_chk(12'h100, 32'h1);
		// Rising edge from timer 0 lands on the clearing edge
		apb(12'h008, 1'h1, 32'h05);
		apb(12'h010, 1'h1, 32'h02);
		apb(12'h004, 1'h1, 32'h0E);
		apb(12'h104, 1'h1, 32'h1);
		fork
			apb(12'h104, 1'h1, 32'h1);
			begin
				@(posedge clk_i);
				drive <= 9'h001;
			end
		join
		rd_chk(12'h104, 32'h1);
		cmp_bit(cell_irq_flag_o[0], 1'h1);
		$display("edge test done");
		apb(12'h004, 1'h1, 32'h8E);
		arst_n_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'h1;
		rd_chk(12'h000, 32'h0);
		rd_chk(12'h004, 32'h0E);
		rd_chk(12'h008, 32'h05);
		$display("retention test done");
		test_done();
	end
endmodule // tb_plc_top
